// ===== core/adc_pkg.sv
// Purpose: shared constants for the stereo converter back end
// Assumes: three-level pins arrive as two-bit level codes
// Notes: ratio thresholds sit midway between legal ratios
package adc_pkg;
   localparam logic [1:0] LVL_LOW = 2'h0; // Pin held low
   localparam logic [1:0] LVL_MID = 2'h1; // Pin at middle level
   localparam logic [1:0] LVL_HIGH = 2'h2; // Pin held high
   localparam int MCLK_HALF_BCLK = 2; // Master ticks per bit clock half
   localparam int SLOTS_PER_CH = 32; // Bit slots per channel
   localparam int SAMPLE_BITS = 24; // Significant sample bits
   localparam int CIC_DECIM = 8; // First stage rate drop
   localparam int CIC_ORDER = 4; // Sinc order
   localparam int CIC_SCALE = 10; // Lift sinc output toward sample MSB
   localparam int HB_STAGES = 3; // Half-band stages
   localparam int MUTE_FRAMES_DEF = 12288; // Frames muted after power-up
   localparam int RATIO_TH1 = 320; // Split 256 from 384
   localparam int RATIO_TH2 = 448; // Split 384 from 512
   localparam int RATIO_TH3 = 640; // Split 512 from 768
   localparam logic [1:0] RATIO_256 = 2'h0; // Ratio codes
   localparam logic [1:0] RATIO_384 = 2'h1;
   localparam logic [1:0] RATIO_512 = 2'h2;
   localparam logic [1:0] RATIO_768 = 2'h3;
endpackage : adc_pkg

// ===== core/adc_serial_out.sv
// Purpose: decimation and serial audio output of a stereo converter
// Assumes: modulator bits are synchronous to core_clk_i
// Notes: pins are sampled, so the master clock must be slower than core_clk_i / 3
// Summary of operation
// - Slave role detects 256/384/512/768 ratio itself
// - Master drives word select fs, bit clock 64 fs
// - Role pin: low slave, high master
// - Format pin: low I2S, high MSB-justified
// - Both formats carry up to 24 bits
// - Fourth-order sinc stage decimates by eight
// - Three half-band stages, each decimating two
// - Seven-tap half-bands: passband droop, shallow stopband attenuation
// - Data held low 12288 frames after power-up
// - Power pin low means power-down; mid 0 dB, high flags 6 dB gain
`timescale 1ns/1ps
module adc_serial_out #(
   parameter int MUTE_FRAMES = adc_pkg::MUTE_FRAMES_DEF
) (
   // Clock, reset, enable
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Strap pins and master clock
   input wire logic master_clock_in_i,
   input wire logic [1:0] role_select_pin_i,
   input wire logic [1:0] format_select_pin_i,
   input wire logic [1:0] power_control_pin_i,
   // Modulator bit streams
   input wire logic mod_l_i,
   input wire logic mod_r_i,
   // Serial port
   input wire logic serial_bit_clock_i,
   output logic serial_bit_clock_o,
   output logic serial_bit_clock_oe_n_o,
   input wire logic word_select_i,
   output logic word_select_o,
   output logic word_select_oe_n_o,
   output logic serial_data_out_o,
   // Status
   output logic gain_6db_o,
   output logic [1:0] clock_ratio_o
);
   import adc_pkg::*;
   localparam int CW = 16; // Sinc accumulator width
   localparam int DW = 26; // Half-band data width
   localparam int MW = $clog2(MUTE_FRAMES + 1); // Mute counter width

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   logic mclk_s1, mclk_s2, mclk_d; // Master clock synchroniser
   logic bclk_s1, bclk_s2, ws_s1, ws_s2; // Port clock synchronisers
   logic [1:0] role_s1, role_s2, fmt_s1, fmt_s2, pwr_s1, pwr_s2; // Straps
   logic bclk_d, ws_d; // Previous selected clocks
   logic [1:0] mdiv; // Master tick divider
   logic [4:0] bit_cnt; // Master bit slot count
   logic master, i2s, powered, clr, run_m, mclk_tick;
   logic bclk_cur, ws_cur, rise, fall, ws_ev, frame_ev;

   // Two flip-flops on every strap and clock pin; modulator bits are not synchronised
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         {mclk_s1, mclk_s2, mclk_d} <= 3'h0;
         {bclk_s1, bclk_s2, ws_s1, ws_s2} <= 4'h0;
         {role_s1, role_s2, fmt_s1, fmt_s2} <= 8'h00;
         {pwr_s1, pwr_s2} <= 4'h0;
      end else if (ce_i) begin
         {mclk_s1, mclk_s2, mclk_d} <= {master_clock_in_i, mclk_s1, mclk_s2};
         {bclk_s1, bclk_s2} <= {serial_bit_clock_i, bclk_s1};
         {ws_s1, ws_s2} <= {word_select_i, ws_s1};
         {role_s1, role_s2} <= {role_select_pin_i, role_s1};
         {fmt_s1, fmt_s2} <= {format_select_pin_i, fmt_s1};
         {pwr_s1, pwr_s2} <= {power_control_pin_i, pwr_s1};
      end
   end

   // Strap decode; middle levels fall back to slave and I2S
   assign master = (role_s2 == LVL_HIGH);
   assign i2s = (fmt_s2 != LVL_HIGH);
   assign powered = (pwr_s2 != LVL_LOW);
   assign clr = rst_i || (ce_i && !powered);
   assign run_m = master && powered;
   assign mclk_tick = mclk_s2 && !mclk_d;
   // Selected port clocks and their edges
   assign bclk_cur = master ? serial_bit_clock_o : bclk_s2;
   assign ws_cur = master ? word_select_o : ws_s2;
   assign rise = bclk_cur && !bclk_d;
   assign fall = !bclk_cur && bclk_d;
   assign ws_ev = ws_cur ^ ws_d;
   assign frame_ev = ws_ev && !ws_cur;

   // Edge history of the selected clocks
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         bclk_d <= 1'b0;
         ws_d <= 1'b0;
      end else if (ce_i) begin
         bclk_d <= bclk_cur;
         ws_d <= ws_cur;
      end
   end

   // Master clock generator: 4 master ticks per bit, 32 bits per half frame
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mdiv <= 2'h0;
         bit_cnt <= 5'h00;
         serial_bit_clock_o <= 1'b0;
         word_select_o <= 1'b0;
         serial_bit_clock_oe_n_o <= 1'b1;
         word_select_oe_n_o <= 1'b1;
      end else if (ce_i) begin
         serial_bit_clock_oe_n_o <= !run_m;
         word_select_oe_n_o <= !run_m;
         if (!run_m) begin
            // Released and idle
            mdiv <= 2'h0;
            bit_cnt <= 5'h00;
            serial_bit_clock_o <= 1'b0;
            word_select_o <= 1'b0;
         end else if (mclk_tick) begin
            // Divider assumes a 256 fs master clock
            mdiv <= mdiv + 2'h1;
            if (mdiv == 2'(MCLK_HALF_BCLK - 1)) begin
               mdiv <= 2'h0;
               serial_bit_clock_o <= !serial_bit_clock_o;
               if (serial_bit_clock_o) begin
                  // Falling edge: next slot
                  bit_cnt <= bit_cnt + 5'h01;
                  if (bit_cnt == 5'(SLOTS_PER_CH - 1)) begin
                     word_select_o <= !word_select_o;
                  end
               end
            end
         end
      end
   end

   // Fourth-order sinc decimator, eight bit-clock samples per output
   logic signed [CW-1:0] integ [2][CIC_ORDER]; // Integrators
   logic signed [CW-1:0] cdly [2][CIC_ORDER]; // Comb delays
   logic signed [CW-1:0] cm [2][CIC_ORDER]; // Comb chain
   logic signed [DW-1:0] cic_out [2]; // Scaled sinc output
   logic [2:0] cic_cnt; // Decimation phase
   logic cic_v; // Sinc output strobe
   logic [1:0] mod_v;
   assign mod_v = {mod_r_i, mod_l_i};

   // Comb chain at the decimated rate
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         cm[c][0] = integ[c][CIC_ORDER-1] - cdly[c][0];
         for (int k = 1; k < CIC_ORDER; k++) begin
            cm[c][k] = cm[c][k-1] - cdly[c][k];
         end
      end
   end

   // Integrators run once per bit clock rise, the 64 fs rate
   always_ff @(posedge core_clk_i) begin
      if (clr) begin
         cic_cnt <= 3'h0;
         cic_v <= 1'b0;
         for (int c = 0; c < 2; c++) begin
            cic_out[c] <= '0;
            for (int k = 0; k < CIC_ORDER; k++) begin
               integ[c][k] <= '0;
               cdly[c][k] <= '0;
            end
         end
      end else if (ce_i) begin
         cic_v <= 1'b0;
         if (rise) begin
            cic_cnt <= cic_cnt + 3'h1;
            for (int c = 0; c < 2; c++) begin
               // Bit maps to +1 or -1
               integ[c][0] <= integ[c][0] + (mod_v[c] ? 16'sh0001 : 16'shffff);
               for (int k = 1; k < CIC_ORDER; k++) begin
                  integ[c][k] <= integ[c][k] + integ[c][k-1];
               end
            end
            if (cic_cnt == 3'(CIC_DECIM - 1)) begin
               cic_v <= 1'b1;
               for (int c = 0; c < 2; c++) begin
                  cdly[c][0] <= integ[c][CIC_ORDER-1];
                  for (int k = 1; k < CIC_ORDER; k++) begin
                     cdly[c][k] <= cm[c][k-1];
                  end
                  cic_out[c] <= DW'(cm[c][CIC_ORDER-1]) <<< CIC_SCALE;
               end
            end
         end
      end
   end

   // Half-band taps -1 0 9 16 9 0 -1 over 32
   function automatic logic signed [DW-1:0] hb_fir(
      input logic signed [DW-1:0] a0, a2, a3, a4, a6);
      logic signed [DW+5:0] e0, e2, e3, e4, e6, acc;
      e0 = (DW+6)'(a0);
      e2 = (DW+6)'(a2);
      e3 = (DW+6)'(a3);
      e4 = (DW+6)'(a4);
      e6 = (DW+6)'(a6);
      acc = (e2 <<< 3) + e2 + (e3 <<< 4) + (e4 <<< 3) + e4 - e0 - e6;
      return DW'(acc >>> 5);
   endfunction : hb_fir

   logic signed [DW-1:0] hdly [HB_STAGES][2][6]; // Tap delay lines
   logic signed [DW-1:0] hx [HB_STAGES][2]; // Stage outputs
   logic signed [DW-1:0] hin [HB_STAGES][2]; // Stage inputs
   logic [HB_STAGES-1:0] hv, hph; // Output strobes, phases
   logic [HB_STAGES:0] vin; // Input strobes
   logic [SAMPLE_BITS-1:0] smp [2]; // Latest frame samples
   assign vin = {hv, cic_v};

   // Stage input selection
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         hin[0][c] = cic_out[c];
         for (int s = 1; s < HB_STAGES; s++) begin
            hin[s][c] = hx[s-1][c];
         end
      end
   end

   // Half-band chain, each stage emits every second input
   always_ff @(posedge core_clk_i) begin
      if (clr) begin
         hv <= '0;
         hph <= '0;
         for (int c = 0; c < 2; c++) begin
            smp[c] <= '0;
            for (int s = 0; s < HB_STAGES; s++) begin
               hx[s][c] <= '0;
               for (int k = 0; k < 6; k++) begin
                  hdly[s][c][k] <= '0;
               end
            end
         end
      end else if (ce_i) begin
         for (int s = 0; s < HB_STAGES; s++) begin
            hv[s] <= 1'b0;
            if (vin[s]) begin
               hph[s] <= !hph[s];
               hv[s] <= hph[s];
               for (int c = 0; c < 2; c++) begin
                  hdly[s][c][0] <= hin[s][c];
                  for (int k = 1; k < 6; k++) begin
                     hdly[s][c][k] <= hdly[s][c][k-1];
                  end
                  if (hph[s]) begin
                     // Response trades stopband depth for size
                     hx[s][c] <= hb_fir(hin[s][c], hdly[s][c][1], hdly[s][c][2],
                        hdly[s][c][3], hdly[s][c][5]);
                  end
               end
            end
         end
         if (hv[HB_STAGES-1]) begin
            // One sample pair per frame
            for (int c = 0; c < 2; c++) begin
               smp[c] <= hx[HB_STAGES-1][c][SAMPLE_BITS-1:0];
            end
         end
      end
   end

   // Mute counter runs in frames after power-up
   logic [MW-1:0] mute_cnt;
   logic muted;
   assign muted = (mute_cnt != MW'(MUTE_FRAMES));
   always_ff @(posedge core_clk_i) begin
      if (clr) begin
         mute_cnt <= '0;
      end else if (ce_i && muted && frame_ev) begin
         mute_cnt <= mute_cnt + MW'(1);
      end
   end

   // Serializer: 32 slots, MSB first, zero tail
   logic [SLOTS_PER_CH-1:0] sh, ld_word;
   logic skip; // Swallows a fall that lags a word edge, until the next rise
   assign ld_word = muted ? '0 : {smp[ws_cur], (SLOTS_PER_CH - SAMPLE_BITS)'(0)};
   always_ff @(posedge core_clk_i) begin
      if (clr) begin
         sh <= '0;
         skip <= 1'b0;
         serial_data_out_o <= 1'b0;
      end else if (ce_i) begin
         if (ws_ev) begin
            skip <= 1'b1;
            if (i2s) begin
               sh <= ld_word;
            end else begin
               serial_data_out_o <= ld_word[SLOTS_PER_CH-1];
               sh <= ld_word << 1;
            end
         end else if (fall) begin
            if (skip) begin
               skip <= 1'b0;
            end else begin
               serial_data_out_o <= sh[SLOTS_PER_CH-1];
               sh <= sh << 1;
            end
         end else if (rise) begin
            skip <= 1'b0;
         end
      end
   end

   // Ratio detector counts master ticks per frame; relies on lock
   logic [9:0] rcnt;
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rcnt <= 10'h000;
         clock_ratio_o <= RATIO_256;
         gain_6db_o <= 1'b0;
      end else if (ce_i) begin
         gain_6db_o <= (pwr_s2 == LVL_HIGH);
         if (master) begin
            clock_ratio_o <= RATIO_256;
         end else if (frame_ev) begin
            rcnt <= 10'h000;
            if (rcnt > 10'(RATIO_TH3)) begin
               clock_ratio_o <= RATIO_768;
            end else if (rcnt > 10'(RATIO_TH2)) begin
               clock_ratio_o <= RATIO_512;
            end else if (rcnt > 10'(RATIO_TH1)) begin
               clock_ratio_o <= RATIO_384;
            end else begin
               clock_ratio_o <= RATIO_256;
            end
         end else if (mclk_tick && rcnt != 10'h3ff) begin
            rcnt <= rcnt + 10'h001;
         end
      end
   end

   // Checks on the generated timing and output
   sequence s_word_start;
      ce_i && powered && ws_ev;
   endsequence
   property p_bclk_div;
      ce_i && run_m && mclk_tick && mdiv == 2'(MCLK_HALF_BCLK - 1) |=> $changed(serial_bit_clock_o);
   endproperty
   a_bclk_div: assert property (p_bclk_div) else $error("bit clock missed divider");
   property p_ws_slots;
      run_m && $past(run_m) && $changed(word_select_o) |->
         $fell(serial_bit_clock_o) && $past(bit_cnt) == 5'(SLOTS_PER_CH - 1);
   endproperty
   a_ws_slots: assert property (p_ws_slots) else $error("word select off slot");
   property p_slave_release;
      ce_i && !run_m |=> serial_bit_clock_oe_n_o && word_select_oe_n_o;
   endproperty
   a_slave_release: assert property (p_slave_release) else $error("slave drives port");
   property p_master_drive;
      ce_i && run_m |=> !serial_bit_clock_oe_n_o && !word_select_oe_n_o;
   endproperty
   a_master_drive: assert property (p_master_drive) else $error("master not driving");
   property p_i2s_delay;
      s_word_start ##0 i2s |=> $stable(serial_data_out_o);
   endproperty
   a_i2s_delay: assert property (p_i2s_delay) else $error("I2S MSB too early");
   property p_msbj_first;
      s_word_start ##0 !i2s |=> serial_data_out_o == $past(ld_word[SLOTS_PER_CH-1]);
   endproperty
   a_msbj_first: assert property (p_msbj_first) else $error("MSB not on word edge");
   property p_mute;
      muted |-> !serial_data_out_o;
   endproperty
   a_mute: assert property (p_mute) else $error("data during mute");
   property p_powerdown;
      ce_i && !powered |=> !serial_data_out_o && serial_bit_clock_oe_n_o;
   endproperty
   a_powerdown: assert property (p_powerdown) else $error("active in power-down");
   property p_cic_rate;
      cic_v |-> cic_cnt == 3'h0 && $past(rise);
   endproperty
   a_cic_rate: assert property (p_cic_rate) else $error("sinc strobe off phase");
   property p_ratio;
      ce_i && !master && frame_ev && rcnt > 10'(RATIO_TH3) |=> clock_ratio_o == RATIO_768;
   endproperty
   a_ratio: assert property (p_ratio) else $error("ratio not 768");
endmodule : adc_serial_out

// ===== dv/adc_serial_out_tb.sv
// Purpose: self-checking bench for the serial output block
// Assumes: short mute count; master clock 256 fs gives a 160 ns bit clock
// Notes: modulator density sets the sample sign; only sign and tail are checked
`timescale 1ns/1ps
module adc_serial_out_tb;
   import adc_pkg::*;
   typedef struct packed {logic [31:0] val; logic [31:0] mask;} exp_s;
   localparam int MUTE = 4; // Shortened mute
   logic core_clk, rst, mclk, mod_l, mod_r, pol, drive, idle_tgl; // Stimulus
   logic [1:0] role, fmt, pwr; // Strap levels
   logic [3:0] half; // Slave bit clock half length
   logic bclk_line, ws_line, p_bclk, p_ws; // Lines and partner clocks
   logic dev_bclk, dev_bclk_oe_n, dev_ws, dev_ws_oe_n, sdata, gain; // Device outputs
   logic [1:0] ratio; // Detected ratio
   logic [31:0] word; // Captured word
   logic [15:0] ones; // Ones seen while muted
   int nslots, wcnt, n_errors, checks, cyc; // Bookkeeping
   exp_s exp_q[$]; // Expected words
   int rat[4] = '{384, 512, 768, 256}; // Slave ratios
   logic [1:0] code[4] = '{RATIO_384, RATIO_512, RATIO_768, RATIO_256}; // Their codes

   // Whoever enables drives; released lines wander
   assign bclk_line = !dev_bclk_oe_n ? dev_bclk : (drive ? p_bclk : idle_tgl);
   assign ws_line = !dev_ws_oe_n ? dev_ws : (drive ? p_ws : ~idle_tgl);

   adc_serial_out #(.MUTE_FRAMES(MUTE)) i_adc_serial_out (
      .core_clk_i(core_clk), .rst_i(rst), .ce_i(1'b1), .master_clock_in_i(mclk),
      .role_select_pin_i(role), .format_select_pin_i(fmt), .power_control_pin_i(pwr),
      .mod_l_i(mod_l), .mod_r_i(mod_r), .serial_bit_clock_i(bclk_line),
      .serial_bit_clock_o(dev_bclk), .serial_bit_clock_oe_n_o(dev_bclk_oe_n),
      .word_select_i(ws_line), .word_select_o(dev_ws), .word_select_oe_n_o(dev_ws_oe_n),
      .serial_data_out_o(sdata), .gain_6db_o(gain), .clock_ratio_o(ratio));

   audio_rx_model i_audio_rx_model (
      .drive_i(drive), .half_ticks_i(half), .bclk_line_i(bclk_line),
      .ws_line_i(ws_line), .data_line_i(sdata), .mclk_o(mclk), .bclk_o(p_bclk),
      .ws_o(p_ws), .word_o(word), .nslots_o(nslots), .word_cnt_o(wcnt));

   // Core clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Idle pattern and hang guard
   always @(posedge core_clk) begin
      idle_tgl <= ~idle_tgl;
      cyc++;
      if (cyc == 90000) begin
         n_errors++;
         $display("mismatch timeout expected %0d seen %0d", 0, cyc);
         finish_test();
      end
   end

   // Random modulator bits, mostly of polarity pol
   initial begin
      void'($urandom(32'h3129));
      forever begin
         @(posedge core_clk);
         mod_l <= ($urandom % 8 == 0) ? ~pol : pol;
         mod_r <= ($urandom % 8 == 0) ? ~pol : pol;
      end
   end

   // Word monitor: oldest note against each finished word
   always @(wcnt) begin
      if (exp_q.size() > 0) begin
         cmp_word(exp_q.pop_front(), word);
         cmp_pin("slots", 32'd32, nslots);
      end
   end

   task automatic cmp_pin(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : cmp_pin

   task automatic cmp_word(input exp_s e, input logic [31:0] got);
      checks++;
      if ((got & e.mask) !== e.val) begin
         n_errors++;
         $display("mismatch word expected %h seen %h", e.val, got & e.mask);
      end
   endtask : cmp_word

   task automatic cycles(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cycles

   // Note four words, wait for the monitor to take them
   task automatic expect_words(input logic [31:0] v, input logic [31:0] m);
      int k;
      exp_s e;
      e.val = v;
      e.mask = m;
      repeat (4) exp_q.push_back(e);
      k = 0;
      while (exp_q.size() > 0 && k < 8000) begin
         @(posedge core_clk);
         k++;
      end
      cmp_pin("words_left", 32'd0, exp_q.size());
   endtask : expect_words

   task automatic finish_test();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test

   // Main sequence
   initial begin
      {rst, drive, fmt, half} = {1'b1, 1'b1, LVL_HIGH, 4'h2};
      {role, pwr, mod_l, mod_r, pol, idle_tgl, ones} = {LVL_LOW, LVL_LOW, 20'h0};
      {n_errors, checks, cyc} = '0;
      cycles(5);
      cmp_pin("data_rst", 32'd0, sdata);
      cmp_pin("bclk_oe_n_rst", 32'd1, dev_bclk_oe_n);
      rst <= 1'b0;
      pwr <= LVL_MID;
      cycles(20);
      // Slave role, clocks from the partner, 0 dB
      cmp_pin("gain_mid", 32'd0, gain);
      cmp_pin("bclk_oe_n", 32'd1, dev_bclk_oe_n);
      cmp_pin("ws_oe_n", 32'd1, dev_ws_oe_n);
      repeat (3 * 1024) begin
         @(posedge core_clk);
         ones += sdata;
      end
      cmp_pin("mute_ones", 32'd0, ones);
      cycles(14 * 1024);
      expect_words(32'h8000_0000, 32'h8000_00ff);
      fmt <= LVL_LOW;
      cycles(2048);
      expect_words(32'h4000_0000, 32'hc000_007f);
      pol <= 1'b1;
      cycles(6 * 1024);
      expect_words(32'h0, 32'hc000_007f);
      // Ratio detection across all four master clock ratios
      foreach (rat[i]) begin
         half <= 4'(rat[i] / 128);
         cycles(12 * rat[i]);
         cmp_pin("ratio", 32'(code[i]), ratio);
      end
      // Master role entered through power-down
      {drive, role, fmt, pwr, pol} <= {1'b0, LVL_HIGH, LVL_HIGH, LVL_LOW, 1'b0};
      cycles(10);
      cmp_pin("pd_oe_n", 32'd1, dev_bclk_oe_n);
      cmp_pin("pd_data", 32'd0, sdata);
      pwr <= LVL_HIGH;
      cycles(20);
      cmp_pin("m_bclk_oe_n", 32'd0, dev_bclk_oe_n);
      cmp_pin("m_ws_oe_n", 32'd0, dev_ws_oe_n);
      cmp_pin("gain_high", 32'd1, gain);
      cmp_pin("m_ratio", 32'd0, ratio);
      cycles(14 * 1024);
      expect_words(32'h8000_0000, 32'h8000_00ff);
      finish_test();
   end
endmodule : adc_serial_out_tb

// ===== dv/audio_rx_model.sv
// Purpose: far-side receiver model, master clock source and slave clock master
// Assumes: master clock period 40 ns; bit clock half is ratio/128 master ticks
// Notes: words are framed by word select changes seen at bit clock rises
`timescale 1ns/1ps
module audio_rx_model (
   // Control from the bench
   input wire logic drive_i,
   input wire logic [3:0] half_ticks_i,
   // Resolved line levels
   input wire logic bclk_line_i,
   input wire logic ws_line_i,
   input wire logic data_line_i,
   // Clocks made here
   output logic mclk_o,
   output logic bclk_o,
   output logic ws_o,
   // Captured channel words
   output logic [31:0] word_o,
   output int nslots_o,
   output int word_cnt_o
);
   int tick; // Master ticks in this half bit
   int slot; // Bit slot within channel
   int n; // Slots captured so far
   logic [31:0] sh; // Capture shift register
   logic ws_prev; // Word select at last rise

   // Master clock runs in every role
   initial begin
      mclk_o = 1'b0;
      forever #20 mclk_o = ~mclk_o;
   end

   // Start state
   initial begin
      {bclk_o, ws_o, ws_prev, sh, word_o} = '0;
      {tick, slot, n, nslots_o, word_cnt_o} = '0;
   end

   // Bit clock and word select divided from master ticks, so locked to it
   always @(posedge mclk_o) begin
      if (!drive_i) begin
         tick = 0;
      end else if (++tick >= half_ticks_i) begin
         tick = 0;
         // Falling bit clock: next slot, word select moves with it
         if (bclk_o) begin
            slot = (slot + 1) % 32;
            if (slot == 0) ws_o = ~ws_o;
         end
         bclk_o = ~bclk_o;
      end
   end

   // Capture data at each bit clock rise
   always @(posedge bclk_line_i) begin
      // Channel boundary: hand over the finished word
      if (ws_line_i !== ws_prev) begin
         word_o = sh;
         nslots_o = n;
         word_cnt_o++;
         sh = '0;
         n = 0;
      end
      ws_prev = ws_line_i;
      if (n < 32) sh[31 - n] = data_line_i;
      n++;
   end
endmodule : audio_rx_model
